/* logic/triangle_setup_parameters.sv */
`timescale 1ns/1ps
module triangle_setup_parameters
	import tri_setup_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Drawing command parameter loads
	input wire logic cmd_valid,
	input wire logic cmd_generic,
	input wire logic [7:0] cmd_offset,
	input wire logic [31:0] cmd_data,
	output logic cmd_ready,
	// Pixel stream
	output logic pixel_valid,
	input wire logic pixel_ready,
	output logic [11:0] pixel_x,
	output logic [11:0] pixel_y,
	output logic [7:0] pixel_red,
	output logic [7:0] pixel_green,
	output logic [7:0] pixel_blue,
	output logic [7:0] pixel_alpha,
	output logic [15:0] pixel_depth,
	// Completion
	output logic frame_done
);
	logic [31:0] p [PARAM_WORDS];
	raster_state_t state_reg;
	raster_state_t state_next;
	logic ctrl_gouraud_reg;
	logic gouraud_reg;
	logic upper_phase_reg;
	logic upper_phase_next;
	logic [SPAN_W-1:0] spans_left_reg;
	logic [SPAN_W-1:0] spans_left_next;
	logic [31:0] y_reg;
	logic [31:0] y_next;
	logic [11:0] pix_x_reg;
	logic [11:0] pix_x_next;
	logic [11:0] span_end_reg;
	logic [11:0] span_end_next;
	logic dir_left_reg;
	logic dir_left_next;
	logic frame_done_reg;
	logic frame_done_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	// APB decode
	logic apb_setup;
	logic apb_wr;
	logic hit_control;
	logic hit_status;
	logic ctrl_wr;
	logic [31:0] status_word;
	logic [31:0] read_value;
	// Sequencing terms
	logic is_idle;
	logic is_setup;
	logic is_pixel;
	logic is_edge;
	logic [SPAN_W-1:0] upper_cnt;
	logic [SPAN_W-1:0] lower_cnt;
	logic start_go;
	logic both_zero;
	logic last_span;
	logic switch_lower;
	logic finish;
	logic pixel_take;
	logic [11:0] pix_x_step;
	logic span_last;
	logic span_empty;
	// Edge walkers
	logic [31:0] long_x;
	logic [31:0] short_x;
	logic [31:0] short_load_value;
	logic [31:0] short_slope;
	logic short_load;
	logic short_step;
	// Interpolated channels: red, green, blue, alpha, depth
	logic [31:0] ch_start [NUM_CHANNELS];
	logic [31:0] ch_hgrad [NUM_CHANNELS];
	logic [31:0] ch_egrad [NUM_CHANNELS];
	logic [31:0] edge_acc [NUM_CHANNELS];
	logic [31:0] pix_acc [NUM_CHANNELS];
	param_store u_store (
		.clk(clk),
		.reset_n(reset_n),
		.load_en(cmd_valid && cmd_ready),
		.load_generic(cmd_generic),
		.load_offset(cmd_offset),
		.load_data(cmd_data),
		.word_reg(p)
	);

	// Parameters are frozen while a triangle is in flight
	assign cmd_ready = is_idle;

	// APB slave: zero wait states, read data captured in the setup phase
	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite;
	assign hit_control = paddr == REG_CONTROL;
	assign hit_status = paddr == REG_STATUS;
	assign ctrl_wr = apb_wr && hit_control;
	assign pready = 1'b1;
	// Parameter space is not mapped for the host, so it answers with an error
	assign pslverr = psel && penable && !(hit_control || hit_status); // see RULE_01
	assign prdata = prdata_reg;

	assign status_word = {4'h0, spans_left_reg, 13'h0000, gouraud_reg, upper_phase_reg,
		!is_idle};
	assign read_value = hit_control ? {31'h0000_0000, ctrl_gouraud_reg} :
		hit_status ? status_word : 32'h0000_0000;
	assign prdata_next = apb_setup ? read_value : prdata_reg;

	// Field pick from the parameter words
	assign upper_cnt = p[OFF_UPPER_SPAN_COUNT[7:2]][27:16];
	assign lower_cnt = p[OFF_LOWER_SPAN_COUNT[7:2]][27:16];

	assign ch_start[0] = p[OFF_RED_START[7:2]];
	assign ch_hgrad[0] = p[OFF_RED_HGRAD[7:2]];
	assign ch_egrad[0] = p[OFF_RED_EGRAD[7:2]];
	assign ch_start[1] = p[OFF_GREEN_START[7:2]];
	assign ch_hgrad[1] = p[OFF_GREEN_HGRAD[7:2]];
	assign ch_egrad[1] = p[OFF_GREEN_EGRAD[7:2]];
	assign ch_start[2] = p[OFF_BLUE_START[7:2]];
	assign ch_hgrad[2] = p[OFF_BLUE_HGRAD[7:2]];
	assign ch_egrad[2] = p[OFF_BLUE_EGRAD[7:2]];
	assign ch_start[3] = p[OFF_ALPHA_START[7:2]];
	assign ch_hgrad[3] = p[OFF_ALPHA_HGRAD[7:2]];
	assign ch_egrad[3] = p[OFF_ALPHA_EGRAD[7:2]];
	assign ch_start[4] = p[OFF_DEPTH_START[7:2]];
	assign ch_hgrad[4] = p[OFF_DEPTH_HGRAD[7:2]];
	assign ch_egrad[4] = p[OFF_DEPTH_EGRAD[7:2]];

	// State terms
	assign is_idle = state_reg == ST_IDLE;
	assign is_setup = state_reg == ST_SETUP;
	assign is_pixel = state_reg == ST_PIXEL;
	assign is_edge = state_reg == ST_EDGE;

	assign start_go = ctrl_wr && pwdata[CTRL_START_BIT] && is_idle;
	assign both_zero = upper_cnt == '0 && lower_cnt == '0; // see RULE_08
	assign last_span = spans_left_reg == SPAN_W'(1);
	assign switch_lower = is_edge && last_span && upper_phase_reg && lower_cnt != '0; // see RULE_18
	assign finish = is_edge && last_span && !switch_lower; // see RULE_09

	// Pixel walk runs from the long edge toward the short edge, end excluded
	assign pixel_take = is_pixel && pixel_ready;
	assign pix_x_step = dir_left_reg ? pix_x_reg - 12'h001 : pix_x_reg + 12'h001;
	assign span_last = pix_x_step == span_end_reg;
	assign span_empty = long_x[27:16] == short_x[27:16];

	// Long edge: loaded at start, stepped on every scan line in both halves
	dda_accumulator #(.W(32)) u_long_x (
		.clk(clk),
		.reset_n(reset_n),
		.load(start_go),
		.load_value(p[OFF_LONG_EDGE_X_START[7:2]]), // see RULE_04
		.step(is_edge), // see RULE_05
		.subtract(1'b0),
		.step_value(p[OFF_LONG_EDGE_X_SLOPE[7:2]]),
		.value_reg(long_x)
	);

	// Short edge: upper start first, lower start when the upper half runs out
	assign short_load = start_go || switch_lower;
	assign short_load_value = (start_go && upper_cnt != '0) ?
		p[OFF_UPPER_EDGE_X_START[7:2]] : p[OFF_LOWER_EDGE_X_START[7:2]]; // see RULE_06
	assign short_slope = upper_phase_reg ?
		p[OFF_UPPER_EDGE_X_SLOPE[7:2]] : p[OFF_LOWER_EDGE_X_SLOPE[7:2]]; // see RULE_07
	assign short_step = is_edge && !last_span;

	dda_accumulator #(.W(32)) u_short_x (
		.clk(clk),
		.reset_n(reset_n),
		.load(short_load),
		.load_value(short_load_value),
		.step(short_step),
		.subtract(1'b0),
		.step_value(short_slope),
		.value_reg(short_x)
	);

	// Per channel: edge accumulator per scan line, pixel accumulator per pixel
	for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_ch
		logic load_live;
		logic step_live;

		// Start always comes with a mode write, so the written mode rules; depth always runs
		assign load_live = pwdata[CTRL_GOURAUD_BIT] || (c == CH_DEPTH); // see RULE_10
		assign step_live = gouraud_reg || (c == CH_DEPTH); // see RULE_10

		dda_accumulator #(.W(32)) u_edge (
			.clk(clk),
			.reset_n(reset_n),
			.load(start_go),
			.load_value(load_live ? ch_start[c] : 32'h0000_0000),
			.step(is_edge && step_live), // see RULE_11 RULE_12 RULE_13 RULE_14 RULE_16
			.subtract(1'b0),
			.step_value(ch_egrad[c]),
			.value_reg(edge_acc[c])
		);

		dda_accumulator #(.W(32)) u_pixel (
			.clk(clk),
			.reset_n(reset_n),
			.load(is_setup),
			.load_value(edge_acc[c]),
			.step(pixel_take && !span_last && step_live), // see RULE_11 RULE_12 RULE_13
			.subtract(dir_left_reg), // see RULE_14 RULE_16
			.step_value(ch_hgrad[c]),
			.value_reg(pix_acc[c])
		);
	end

	// Sequencer
	always_comb begin
		state_next = state_reg;
		upper_phase_next = upper_phase_reg;
		spans_left_next = spans_left_reg;
		y_next = y_reg;
		pix_x_next = pix_x_reg;
		span_end_next = span_end_reg;
		dir_left_next = dir_left_reg;
		frame_done_next = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (start_go) begin
					y_next = p[OFF_LONG_EDGE_Y_START[7:2]]; // see RULE_04
					upper_phase_next = upper_cnt != '0; // see RULE_08
					spans_left_next = (upper_cnt != '0) ? upper_cnt : lower_cnt;
					if (both_zero) begin
						frame_done_next = 1'b1;
					end else begin
						state_next = ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				pix_x_next = long_x[27:16];
				span_end_next = short_x[27:16];
				dir_left_next = $signed(short_x[27:16]) < $signed(long_x[27:16]);
				state_next = span_empty ? ST_EDGE : ST_PIXEL; // see RULE_18
			end
			ST_PIXEL: begin
				if (pixel_take) begin
					pix_x_next = pix_x_step;
					if (span_last) begin
						state_next = ST_EDGE;
					end
				end
			end
			ST_EDGE: begin
				y_next = y_reg + Y_STEP_ONE;
				if (switch_lower) begin
					upper_phase_next = 1'b0;
					spans_left_next = lower_cnt; // see RULE_09
					state_next = ST_SETUP;
				end else if (finish) begin
					spans_left_next = '0;
					frame_done_next = 1'b1;
					state_next = ST_IDLE;
				end else begin
					spans_left_next = spans_left_reg - SPAN_W'(1);
					state_next = ST_SETUP;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			upper_phase_reg <= 1'b0;
			spans_left_reg <= '0;
			y_reg <= '0;
			pix_x_reg <= '0;
			span_end_reg <= '0;
			dir_left_reg <= 1'b0;
			frame_done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			upper_phase_reg <= upper_phase_next;
			spans_left_reg <= spans_left_next;
			y_reg <= y_next;
			pix_x_reg <= pix_x_next;
			span_end_reg <= span_end_next;
			dir_left_reg <= dir_left_next;
			frame_done_reg <= frame_done_next;
		end
	end

	// Shading mode is latched at start so a mid-triangle write cannot tear it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_gouraud_reg <= CTRL_GOURAUD_RESET;
			gouraud_reg <= CTRL_GOURAUD_RESET;
			prdata_reg <= '0;
		end else begin
			if (ctrl_wr) begin
				ctrl_gouraud_reg <= pwdata[CTRL_GOURAUD_BIT];
			end
			if (start_go) begin
				gouraud_reg <= pwdata[CTRL_GOURAUD_BIT]; // see RULE_10
			end
			prdata_reg <= prdata_next;
		end
	end

	// Outputs
	assign pixel_valid = is_pixel;
	assign pixel_x = pix_x_reg;
	assign pixel_y = y_reg[27:16];
	assign pixel_red = pix_acc[0][23:16];
	assign pixel_green = pix_acc[1][23:16];
	assign pixel_blue = pix_acc[2][23:16];
	assign pixel_alpha = pix_acc[3][23:16];
	assign pixel_depth = pix_acc[CH_DEPTH][30:15];
	assign frame_done = frame_done_reg;

	a_host_refused: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_01
		psel && penable && paddr < PARAM_SPACE_END |-> pslverr && prdata == 32'h0000_0000)
		else $error("host reached parameter space");
	a_long_edge_start: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_04
		start_go |=> long_x == $past(p[OFF_LONG_EDGE_X_START[7:2]])
		&& y_reg == $past(p[OFF_LONG_EDGE_Y_START[7:2]]))
		else $error("long edge start not loaded");
	a_long_edge_step: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_05
		is_edge |=> long_x == $past(long_x) + $past(p[OFF_LONG_EDGE_X_SLOPE[7:2]])
		&& y_reg == $past(y_reg) + Y_STEP_ONE)
		else $error("long edge step wrong");
	a_upper_edge_step: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_06
		is_edge && upper_phase_reg && !last_span
		|=> short_x == $past(short_x) + $past(p[OFF_UPPER_EDGE_X_SLOPE[7:2]]))
		else $error("upper edge step wrong");
	a_lower_switch: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_07
		switch_lower |=> short_x == $past(p[OFF_LOWER_EDGE_X_START[7:2]])
		&& !upper_phase_reg && spans_left_reg == $past(lower_cnt) && is_setup)
		else $error("lower edge not started");
	a_upper_skip: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_08
		start_go && upper_cnt == '0 && lower_cnt != '0
		|=> !upper_phase_reg && spans_left_reg == $past(lower_cnt) ##1 is_pixel || is_edge)
		else $error("empty upper half not skipped");
	a_lower_finish: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_09
		is_edge && last_span && (!upper_phase_reg || lower_cnt == '0)
		|=> is_idle && frame_done ##1 !frame_done)
		else $error("triangle did not end after last span");
	a_flat_colour: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_10
		is_pixel && !gouraud_reg |-> pixel_red == 8'h00 && pixel_green == 8'h00
		&& pixel_blue == 8'h00 && pixel_alpha == 8'h00)
		else $error("colour used outside Gouraud");
	a_red_pixel_step: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_11
		pixel_take && !span_last && !dir_left_reg && gouraud_reg
		|=> pix_acc[0] == $past(pix_acc[0]) + $past(ch_hgrad[0]))
		else $error("red pixel step wrong");
	a_depth_edge_step: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_16
		is_edge |=> edge_acc[CH_DEPTH] == $past(edge_acc[CH_DEPTH]) + $past(ch_egrad[CH_DEPTH]))
		else $error("depth edge step wrong");
	a_span_load: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_18
		is_setup |=> pix_x_reg == $past(long_x[27:16]) && pix_acc[0] == $past(edge_acc[0]))
		else $error("span did not start at long edge");
endmodule

/* common/tri_setup_pkg.sv */
package tri_setup_pkg;
// Contract
// RULE_01: Parameters load only from drawing commands; host and generic writes cannot touch them.
// RULE_02: Each parameter sits at a fixed offset, long edge Y start at zero.
// RULE_03: Edge values are signed: 31..28 sign, 27..16 integer, 15..0 fraction.
// RULE_04: Long edge starts at stored Y start, X start is X there.
// RULE_05: Long edge X gains its slope once per scan line stepped.
// RULE_06: Upper edge starts at its X start, steps by its slope per line.
// RULE_07: Lower edge starts at its X start, steps by its slope per line.
// RULE_08: Upper sub-triangle draws upper count spans, none when count is zero.
// RULE_09: Lower sub-triangle draws lower count spans, none when count is zero.
// RULE_10: Colour and alpha parameters are used only in Gouraud shading.
// RULE_11: Red starts at long edge, steps horizontally per pixel, edge-wise per line.
// RULE_12: Green starts at long edge, steps horizontally per pixel, edge-wise per line.
// RULE_13: Blue starts at long edge, steps horizontally per pixel, edge-wise per line.
// RULE_14: Alpha starts at long edge, steps horizontally per pixel, edge-wise per line.
// RULE_15: Colour starts unsigned 23..0; edge colour gradients sign-extended in 31..24.
// RULE_16: Depth starts at long edge, steps horizontally per pixel, edge-wise per line.
// RULE_17: Depth start has bit 31 zero; depth gradients signed, integer 30..15.
// RULE_18: Upper spans before lower; long edge runs through both, spans reach short edge. The code stops each span one pixel before the short edge.

	localparam int PARAM_WORDS = 36;
	localparam int SPAN_W = 12;
	localparam logic [7:0] OFF_LONG_EDGE_Y_START = 8'h00;
	localparam logic [7:0] OFF_LONG_EDGE_X_START = 8'h04;
	localparam logic [7:0] OFF_LONG_EDGE_X_SLOPE = 8'h08;
	localparam logic [7:0] OFF_UPPER_EDGE_X_START = 8'h0c;
	localparam logic [7:0] OFF_UPPER_EDGE_X_SLOPE = 8'h10;
	localparam logic [7:0] OFF_LOWER_EDGE_X_START = 8'h14;
	localparam logic [7:0] OFF_LOWER_EDGE_X_SLOPE = 8'h18;
	localparam logic [7:0] OFF_UPPER_SPAN_COUNT = 8'h1c;
	localparam logic [7:0] OFF_LOWER_SPAN_COUNT = 8'h20;
	localparam logic [7:0] OFF_RED_START = 8'h40;
	localparam logic [7:0] OFF_RED_HGRAD = 8'h44;
	localparam logic [7:0] OFF_RED_EGRAD = 8'h48;
	localparam logic [7:0] OFF_GREEN_START = 8'h4c;
	localparam logic [7:0] OFF_GREEN_HGRAD = 8'h50;
	localparam logic [7:0] OFF_GREEN_EGRAD = 8'h54;
	localparam logic [7:0] OFF_BLUE_START = 8'h58;
	localparam logic [7:0] OFF_BLUE_HGRAD = 8'h5c;
	localparam logic [7:0] OFF_BLUE_EGRAD = 8'h60;
	localparam logic [7:0] OFF_ALPHA_START = 8'h64;
	localparam logic [7:0] OFF_ALPHA_HGRAD = 8'h68;
	localparam logic [7:0] OFF_ALPHA_EGRAD = 8'h6c;
	localparam logic [7:0] OFF_DEPTH_START = 8'h80;
	localparam logic [7:0] OFF_DEPTH_HGRAD = 8'h84;
	localparam logic [7:0] OFF_DEPTH_EGRAD = 8'h8c;
	localparam int FIX_INT_LSB = 16;
	localparam int FIX_SIGN_LSB = 28;
	localparam int COLOUR_SIGN_LSB = 24;
	localparam int DEPTH_INT_LSB = 15;
	localparam int DEPTH_SIGN_BIT = 31;
	localparam logic [31:0] Y_STEP_ONE = 32'h0001_0000;
	localparam int NUM_CHANNELS = 5;
	localparam int CH_DEPTH = 4;
	localparam logic [11:0] REG_CONTROL = 12'h400;
	localparam logic [11:0] REG_STATUS = 12'h404;
	localparam logic [11:0] PARAM_SPACE_END = 12'h100;
	localparam int CTRL_GOURAUD_BIT = 0;
	localparam int CTRL_START_BIT = 1;
	localparam logic CTRL_GOURAUD_RESET = 1'b0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_UPPER_BIT = 1;
	localparam int STAT_GOURAUD_BIT = 2;
	localparam int STAT_SPANS_LSB = 16;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SETUP = 4'b0010,
		ST_PIXEL = 4'b0100,
		ST_EDGE = 4'b1000
	} raster_state_t;
endpackage

/* logic/dda_accumulator.sv */
`timescale 1ns/1ps
module dda_accumulator
	import tri_setup_pkg::*;
#(
	parameter int W = 32
)(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Control
	input wire logic load,
	input wire logic [W-1:0] load_value,
	input wire logic step,
	input wire logic subtract,
	input wire logic [W-1:0] step_value,
	// Result
	output logic [W-1:0] value_reg
);
	logic [W-1:0] value_next;

	// Load wins over step so a fresh start never inherits a stale increment
	assign value_next = load ? load_value :
		step ? (subtract ? value_reg - step_value : value_reg + step_value) : value_reg;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			value_reg <= '0;
		end else begin
			value_reg <= value_next;
		end
	end
endmodule

/* logic/param_store.sv */
`timescale 1ns/1ps
module param_store
	import tri_setup_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Command load
	input wire logic load_en,
	input wire logic load_generic,
	input wire logic [7:0] load_offset,
	input wire logic [31:0] load_data,
	// Stored words
	output logic [31:0] word_reg [PARAM_WORDS]
);
	logic [5:0] load_index;
	logic load_hit;
	logic [31:0] shaped;

	function automatic logic [31:0] shape(input logic [7:0] off, input logic [31:0] d);
		case (off)
			OFF_UPPER_SPAN_COUNT, OFF_LOWER_SPAN_COUNT: shape = {4'h0, d[27:16], 16'h0000};
			OFF_RED_START, OFF_GREEN_START, OFF_BLUE_START, OFF_ALPHA_START: begin
				shape = {8'h00, d[23:0]}; // see RULE_15
			end
			OFF_RED_EGRAD, OFF_GREEN_EGRAD, OFF_BLUE_EGRAD, OFF_ALPHA_EGRAD: begin
				shape = {{8{d[23]}}, d[23:0]}; // see RULE_15
			end
			OFF_DEPTH_START: shape = {1'b0, d[30:0]}; // see RULE_17
			OFF_DEPTH_HGRAD, OFF_DEPTH_EGRAD: shape = d; // see RULE_17
			default: shape = {{4{d[27]}}, d[27:0]}; // see RULE_03
		endcase
	endfunction

	assign load_index = load_offset[7:2]; // see RULE_02
	assign load_hit = load_en && !load_generic && (load_offset < 8'(PARAM_WORDS * 4)); // see RULE_01
	assign shaped = shape(load_offset, load_data);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < PARAM_WORDS; i++) begin
				word_reg[i] <= '0;
			end
		end else if (load_hit) begin
			word_reg[load_index] <= shaped;
		end
	end

	a_generic_ignored: assert property (@(posedge clk) disable iff (!reset_n) // see RULE_01
		load_en && load_generic && load_offset < 8'(PARAM_WORDS * 4)
		|=> word_reg[$past(load_index)] == $past(word_reg[load_index]))
		else $error("generic write changed a parameter");
endmodule

/* tb/cmd_proc_model.sv */
`timescale 1ns/1ps
module cmd_proc_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Parameter loads
	output logic cmd_valid,
	output logic cmd_generic,
	output logic [7:0] cmd_offset,
	output logic [31:0] cmd_data,
	input wire logic cmd_ready
);
	initial begin
		cmd_valid = 1'b0;
		cmd_generic = 1'b0;
		cmd_offset = 8'hff;
		cmd_data = 32'h0;
	end
	// Held until accepted; afterwards the bus shows junk so stale data never matches
	task automatic load(input logic [7:0] off, input logic [31:0] data, input logic gen);
		@(posedge clk);
		cmd_valid <= reset_n;
		cmd_generic <= gen;
		cmd_offset <= off;
		cmd_data <= data;
		// No cycle limit of its own: the bench watchdog ends a hang
		do begin
			@(posedge clk);
		end while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		cmd_offset <= ~off;
		cmd_data <= ~data;
	endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import tri_setup_pkg::*;
;
	typedef struct packed {
		logic w;
		logic [11:0] a;
		logic [31:0] d;
		logic e;
		logic [31:0] x;
	} apb_row_t;
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic cmd_valid, cmd_generic, cmd_ready, pixel_valid, frame_done, err;
	logic pixel_ready = 1'b0;
	logic [7:0] cmd_offset, pixel_red, pixel_green, pixel_blue, pixel_alpha;
	logic [31:0] cmd_data;
	logic [11:0] pixel_x, pixel_y;
	logic [15:0] pixel_depth;
	logic [71:0] exp_q [$];
	int bad_count = 0;
	int n_compared = 0;
	int i;
	apb_row_t rows [8] = '{
		'{1'b1, REG_CONTROL, 32'h1, 1'b0, 32'h0}, '{1'b0, REG_CONTROL, 32'h0, 1'b0, 32'h1},
		'{1'b1, REG_CONTROL, 32'h0, 1'b0, 32'h0}, '{1'b0, REG_CONTROL, 32'h0, 1'b0, 32'h0},
		'{1'b1, 12'h000, 32'h1234, 1'b1, 32'h0}, '{1'b0, 12'h000, 32'h0, 1'b1, 32'h0},
		'{1'b0, 12'h020, 32'h0, 1'b1, 32'h0}, '{1'b0, 12'h408, 32'h0, 1'b1, 32'h0}};
	logic [39:0] loads [21] = '{
		{OFF_LONG_EDGE_Y_START, 32'h000a_0000}, {OFF_LONG_EDGE_X_START, 32'h0005_0000},
		{OFF_LONG_EDGE_X_SLOPE, 32'h0fff_0000}, {OFF_UPPER_EDGE_X_START, 32'h0008_0000},
		{OFF_UPPER_EDGE_X_SLOPE, 32'h0001_0000}, {OFF_LOWER_EDGE_X_START, 32'h0009_0000},
		{OFF_UPPER_SPAN_COUNT, 32'h0002_0000}, {OFF_LOWER_SPAN_COUNT, 32'h0001_0000},
		{OFF_RED_START, 32'hff10_0000}, {OFF_RED_HGRAD, 32'h0001_0000},
		{OFF_RED_EGRAD, 32'h0002_0000}, {OFF_GREEN_START, 32'h0020_0000},
		{OFF_GREEN_EGRAD, 32'h00ff_0000}, {OFF_BLUE_START, 32'h0030_0000},
		{OFF_BLUE_HGRAD, 32'h0001_0000}, {OFF_ALPHA_START, 32'h0040_0000},
		{OFF_ALPHA_EGRAD, 32'h0001_0000}, {OFF_DEPTH_START, 32'h0000_8000},
		{OFF_DEPTH_HGRAD, 32'h0000_8000}, {OFF_DEPTH_EGRAD, 32'h0001_0000},
		{OFF_LOWER_EDGE_X_SLOPE, 32'h0}};

	triangle_setup_parameters uut (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_generic(cmd_generic),
		.cmd_offset(cmd_offset), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
		.pixel_valid(pixel_valid), .pixel_ready(pixel_ready), .pixel_x(pixel_x),
		.pixel_y(pixel_y), .pixel_red(pixel_red), .pixel_green(pixel_green),
		.pixel_blue(pixel_blue), .pixel_alpha(pixel_alpha), .pixel_depth(pixel_depth),
		.frame_done(frame_done));
	cmd_proc_model cmd (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
		.cmd_generic(cmd_generic), .cmd_offset(cmd_offset), .cmd_data(cmd_data),
		.cmd_ready(cmd_ready));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_pix(input logic [71:0] got, input logic [71:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Waits as long as the slave needs; only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Pixels walk from the long edge toward the short edge, short end left out
	task automatic set_exp(input logic gour);
		int n, k, lx, sx;
		for (n = 0; n < 3; n++) begin
			lx = 5 - n;
			sx = (n < 2) ? 8 + n : 9;
			for (k = 0; k < sx - lx; k++) begin
				exp_q.push_back({12'(lx + k), 12'(10 + n), gour ? {8'(16 + k + 2 * n),
					8'(32 - n), 8'(48 + k), 8'(64 + n)} : 32'h0, 16'(1 + k + 2 * n)});
			end
		end
	endtask

	task automatic wait_done();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (frame_done !== 1'b1 && n < 500);
		check_word(32'(n < 500), 32'h1);
		check_word(exp_q.size(), 32'h0);
	endtask

	// Stalls the pixel stream every other cycle
	always @(posedge clk) begin
		pixel_ready <= ~pixel_ready;
		if (pixel_valid === 1'b1 && pixel_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				check_pix({pixel_x, pixel_y, pixel_red, pixel_green, pixel_blue, pixel_alpha,
					pixel_depth}, 72'hffff_ffff_ffff_ffff_ff);
			end else begin
				check_pix({pixel_x, pixel_y, pixel_red, pixel_green, pixel_blue, pixel_alpha,
					pixel_depth}, exp_q.pop_front());
			end
		end
	end

	initial begin
		#100000;
		bad_count++;
		report_and_stop();
	end

	initial begin
		reset_n = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		check_word({prdata[0], cmd_ready, pixel_valid, frame_done}, 32'h4);
		for (i = 0; i < 8; i++) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			check_word(err, rows[i].e);
			if (!rows[i].w) begin
				check_word(rd, rows[i].x);
			end
		end
		for (i = 0; i < 21; i++) begin
			cmd.load(loads[i][39:32], loads[i][31:0], 1'b0);
		end
		cmd.load(OFF_UPPER_SPAN_COUNT, 32'h0, 1'b1);
		set_exp(1'b1);
		apb(1'b1, REG_CONTROL, 32'h3);
		while (pixel_valid !== 1'b1) @(posedge clk);
		apb(1'b0, REG_STATUS, 32'h0);
		check_word(rd & 32'h7, 32'h7);
		wait_done();
		set_exp(1'b0);
		apb(1'b1, REG_CONTROL, 32'h2);
		wait_done();
		cmd.load(OFF_UPPER_SPAN_COUNT, 32'h0, 1'b0);
		cmd.load(OFF_LOWER_SPAN_COUNT, 32'h0, 1'b0);
		apb(1'b1, REG_CONTROL, 32'h2);
		wait_done();
		// Lower half only, short edge left of the long edge: gradients run backwards
		cmd.load(OFF_LOWER_SPAN_COUNT, 32'h0001_0000, 1'b0);
		cmd.load(OFF_LOWER_EDGE_X_START, 32'h0002_0000, 1'b0);
		for (i = 0; i < 3; i++) begin
			exp_q.push_back({12'(5 - i), 12'h00a, 8'(16 - i), 8'h20, 8'(48 - i), 8'h40,
				16'(1 - i)});
		end
		apb(1'b1, REG_CONTROL, 32'h3);
		wait_done();
		repeat (4) @(posedge clk);
		report_and_stop();
	end
endmodule
